// *** logic/pec_defs.vh ***
`ifndef PEC_DEFS_VH
`define PEC_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PEC_RX_ERR_BASE 16'h0300
`define PEC_RX_ERR_LAST 16'h0307
`define PEC_FWD_ERR_BASE 16'h0308
`define PEC_FWD_ERR_LAST 16'h030B
`define PEC_FRAME_UNIT_ERR 16'h030C
`define PEC_HOST_IF_ERR_CNT 16'h030D
`define PEC_HOST_IF_CODE_LO 16'h030E
`define PEC_HOST_IF_CODE_HI 16'h030F

// ----------------------------------------------------------------
// Reset and counter limits
// ----------------------------------------------------------------
`define PEC_CNT_RESET 8'h00
`define PEC_CNT_MAX 8'hFF
`define PEC_CNT_ONE 8'h01
`define PEC_CODE_RESET 16'h0000
`define PEC_RDATA_RESET 8'h00

// ----------------------------------------------------------------
// Fields of the receive counter word
// ----------------------------------------------------------------
`define PEC_RX_INVALID_LSB 0
`define PEC_RX_PHY_LSB 8

// ----------------------------------------------------------------
// Host interface variants
// ----------------------------------------------------------------
`define PEC_HIF_SPI 3'h0
`define PEC_HIF_MCU8 3'h1
`define PEC_HIF_MCU16 3'h2
`define PEC_HIF_MM 3'h3
`define PEC_HIF_AXI 3'h4

// ----------------------------------------------------------------
// Reason code bit positions
// ----------------------------------------------------------------
`define PEC_SPI_CYC_LSB 0
`define PEC_SPI_BUSY_RD 3
`define PEC_SPI_NO_TERM 4
`define PEC_SPI_AFTER_TERM 5
`define PEC_SPI_SEL_LSB 6
`define PEC_MCU_BUSY_RD 0
`define PEC_MCU_BUSY_WR 1
`define PEC_MCU_ODD_RD 2
`define PEC_MCU_ODD_WR 3
`define PEC_MM_BOTH 0
`define PEC_AXI_AW_DROP 0
`define PEC_AXI_W_DROP 1
`define PEC_AXI_AR_DROP 2
`define PEC_AXI_AW_SIZE 3
`define PEC_AXI_AR_SIZE 4

// Largest supported AXI transfer size code (4 bytes)
`define PEC_AXI_MAX_SIZE 3'h2

`endif

// *** logic/pec_error_counters.v ***
`timescale 1ns/1ps

`include "pec_defs.vh"

//Function
// - Low byte counts invalid frames, saturating
// - High byte counts receive errors, saturating
// - Write to port counters clears them all
// - Port counts only while loop open
// - Byte per port counts forwarded errors
// - Saturating count of frame unit errors
// - Frame unit counter cleared by own write
// - Saturating count of host interface errors
// - Host counter write clears counter and code
// - Reason code read-only, unused bits zero
// - Serial: bits 2:0 clock cycles mod 8
// - Serial: busy, no termination, after termination
// - Serial: bits 7:6 command or select bits
// - Bus: busy violation on read, write
// - 16-bit bus: odd address without high enable
// - Memory-mapped: read and write together
// - AXI: valid withdrawn before ready
// - AXI: write, read size too large
module pec_error_counters
#(
   parameter [2:0] HIF_VARIANT = `PEC_HIF_SPI
)
(
   input wire clock,
   input wire rst,
   input wire [15:0] net_addr,
   input wire net_wr,
   input wire net_rd,
   output reg [7:0] net_rdata_q,
   input wire [15:0] host_addr,
   input wire host_rd,
   output reg [7:0] host_rdata_q,
   input wire [3:0] port_loop_open,
   input wire [3:0] port_invalid_frame,
   input wire [3:0] port_rx_err,
   input wire [3:0] port_fwd_err,
   input wire frame_unit_err,
   input wire spi_err,
   input wire [2:0] spi_clk_cycles,
   input wire spi_busy_rd,
   input wire spi_no_term,
   input wire spi_after_term,
   input wire [2:0] spi_cmd,
   input wire spi_sel_mosi,
   input wire spi_sel_miso,
   input wire spi_ext_sel,
   input wire mcu_rd_end,
   input wire mcu_wr_end,
   input wire mcu_busy,
   input wire mcu_addr0,
   input wire mcu_high_byte_enable_n,
   input wire mm_read,
   input wire mm_write,
   input wire axi_awvalid,
   input wire axi_awready,
   input wire [2:0] axi_awsize,
   input wire axi_wvalid,
   input wire axi_wready,
   input wire axi_arvalid,
   input wire axi_arready,
   input wire [2:0] axi_arsize
);

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
wire [31:0] invalid_cnt;
wire [31:0] phy_cnt;
wire [31:0] fwd_cnt;
wire [7:0] frame_unit_cnt;
wire [7:0] host_if_cnt;
reg [15:0] reason_q;
reg [15:0] reason_d;
reg hif_err;
reg mm_both_q;
reg aw_pend_q;
reg w_pend_q;
reg ar_pend_q;
wire port_clr;
wire frame_unit_clr;
wire host_if_clr;
wire mm_both;
wire aw_drop;
wire w_drop;
wire ar_drop;
wire aw_big;
wire ar_big;
wire mcu_busy_rd;
wire mcu_busy_wr;
wire mcu_odd_rd;
wire mcu_odd_wr;

// ----------------------------------------------------------------
// Clear decode
// ----------------------------------------------------------------
// Written data is ignored, so no data port exists on this side
assign port_clr = net_wr && (net_addr >= `PEC_RX_ERR_BASE) &&
   (net_addr <= `PEC_FWD_ERR_LAST);
assign frame_unit_clr = net_wr &&
   (net_addr == `PEC_FRAME_UNIT_ERR);
assign host_if_clr = net_wr &&
   (net_addr == `PEC_HOST_IF_ERR_CNT);

// ----------------------------------------------------------------
// Per-port counters
// ----------------------------------------------------------------
genvar p;
generate
   for (p = 0; p < 4; p = p + 1)
   begin : g_port
      pec_sat_cnt u_invalid
      (
         .clock(clock),
         .rst(rst),
         .clr(port_clr),
         .inc(port_invalid_frame[p] & port_loop_open[p]),
         .count_q(invalid_cnt[8*p+7:8*p])
      );
      pec_sat_cnt u_phy
      (
         .clock(clock),
         .rst(rst),
         .clr(port_clr),
         .inc(port_rx_err[p] & port_loop_open[p]),
         .count_q(phy_cnt[8*p+7:8*p])
      );
      pec_sat_cnt u_fwd
      (
         .clock(clock),
         .rst(rst),
         .clr(port_clr),
         .inc(port_fwd_err[p] & port_loop_open[p]),
         .count_q(fwd_cnt[8*p+7:8*p])
      );
   end
endgenerate

// ----------------------------------------------------------------
// Frame unit and host interface counters
// ----------------------------------------------------------------
pec_sat_cnt u_frame_unit
(
   .clock(clock),
   .rst(rst),
   .clr(frame_unit_clr),
   .inc(frame_unit_err),
   .count_q(frame_unit_cnt)
);

pec_sat_cnt u_host_if
(
   .clock(clock),
   .rst(rst),
   .clr(host_if_clr),
   .inc(hif_err),
   .count_q(host_if_cnt)
);

// ----------------------------------------------------------------
// Bus error detection
// ----------------------------------------------------------------
assign mcu_busy_rd = mcu_rd_end & mcu_busy;
assign mcu_busy_wr = mcu_wr_end & mcu_busy;
assign mcu_odd_rd = mcu_rd_end & mcu_addr0 & mcu_high_byte_enable_n;
assign mcu_odd_wr = mcu_wr_end & mcu_addr0 & mcu_high_byte_enable_n;

// One error per overlap, not one per cycle of it
assign mm_both = mm_read & mm_write;

// Pending means valid was up without ready in the last cycle
assign aw_drop = aw_pend_q & ~axi_awvalid;
assign w_drop = w_pend_q & ~axi_wvalid;
assign ar_drop = ar_pend_q & ~axi_arvalid;
assign aw_big = axi_awvalid & axi_awready &
   (axi_awsize > `PEC_AXI_MAX_SIZE);
assign ar_big = axi_arvalid & axi_arready &
   (axi_arsize > `PEC_AXI_MAX_SIZE);

always @(posedge clock)
begin
   if (rst)
   begin
      mm_both_q <= 1'b0;
      aw_pend_q <= 1'b0;
      w_pend_q <= 1'b0;
      ar_pend_q <= 1'b0;
   end
   else
   begin
      mm_both_q <= mm_both;
      aw_pend_q <= axi_awvalid & ~axi_awready;
      w_pend_q <= axi_wvalid & ~axi_wready;
      ar_pend_q <= axi_arvalid & ~axi_arready;
   end
end

// ----------------------------------------------------------------
// Reason code assembly
// ----------------------------------------------------------------
// Variant is fixed at build time; other variants' inputs are unused
always @*
begin
   reason_d = `PEC_CODE_RESET;
   hif_err = 1'b0;
   case (HIF_VARIANT)
      `PEC_HIF_SPI:
      begin
         hif_err = spi_err;
         reason_d[`PEC_SPI_CYC_LSB+2:`PEC_SPI_CYC_LSB] =
            spi_clk_cycles;
         reason_d[`PEC_SPI_BUSY_RD] = spi_busy_rd;
         reason_d[`PEC_SPI_NO_TERM] = spi_no_term;
         reason_d[`PEC_SPI_AFTER_TERM] = spi_after_term;
         if (spi_ext_sel)
            reason_d[`PEC_SPI_SEL_LSB+1:`PEC_SPI_SEL_LSB] =
               {spi_sel_mosi, spi_sel_miso};
         else
            reason_d[`PEC_SPI_SEL_LSB+1:`PEC_SPI_SEL_LSB] =
               spi_cmd[2:1];
      end
      `PEC_HIF_MCU8:
      begin
         hif_err = mcu_busy_rd | mcu_busy_wr;
         reason_d[`PEC_MCU_BUSY_RD] = mcu_busy_rd;
         reason_d[`PEC_MCU_BUSY_WR] = mcu_busy_wr;
      end
      `PEC_HIF_MCU16:
      begin
         hif_err = mcu_busy_rd | mcu_busy_wr | mcu_odd_rd | mcu_odd_wr;
         reason_d[`PEC_MCU_BUSY_RD] = mcu_busy_rd;
         reason_d[`PEC_MCU_BUSY_WR] = mcu_busy_wr;
         reason_d[`PEC_MCU_ODD_RD] = mcu_odd_rd;
         reason_d[`PEC_MCU_ODD_WR] = mcu_odd_wr;
      end
      `PEC_HIF_MM:
      begin
         hif_err = mm_both & ~mm_both_q;
         reason_d[`PEC_MM_BOTH] = 1'b1;
      end
      `PEC_HIF_AXI:
      begin
         hif_err = aw_drop | w_drop | ar_drop | aw_big | ar_big;
         reason_d[`PEC_AXI_AW_DROP] = aw_drop;
         reason_d[`PEC_AXI_W_DROP] = w_drop;
         reason_d[`PEC_AXI_AR_DROP] = ar_drop;
         reason_d[`PEC_AXI_AW_SIZE] = aw_big;
         reason_d[`PEC_AXI_AR_SIZE] = ar_big;
      end
      default:
      begin
         hif_err = 1'b0;
         reason_d = `PEC_CODE_RESET;
      end
   endcase
end

// New error beats a clear in the same cycle
always @(posedge clock)
begin
   if (rst)
      reason_q <= `PEC_CODE_RESET;
   else if (hif_err)
      reason_q <= reason_d;
   else if (host_if_clr)
      reason_q <= `PEC_CODE_RESET;
end

// ----------------------------------------------------------------
// Read paths
// ----------------------------------------------------------------
// Both sides share one byte map; the code is never writable
function [7:0] read_byte;
   input [15:0] addr;
   reg [15:0] off;
   begin
      off = addr - `PEC_RX_ERR_BASE;
      read_byte = 8'h00;
      if (addr >= `PEC_RX_ERR_BASE && addr <= `PEC_RX_ERR_LAST)
      begin
         if (off[0])
            read_byte = phy_cnt[8*off[2:1] +: 8];
         else
            read_byte = invalid_cnt[8*off[2:1] +: 8];
      end
      else if (addr >= `PEC_FWD_ERR_BASE && addr <= `PEC_FWD_ERR_LAST)
         read_byte = fwd_cnt[8*off[1:0] +: 8];
      else if (addr == `PEC_FRAME_UNIT_ERR)
         read_byte = frame_unit_cnt;
      else if (addr == `PEC_HOST_IF_ERR_CNT)
         read_byte = host_if_cnt;
      else if (addr == `PEC_HOST_IF_CODE_LO)
         read_byte = reason_q[7:0];
      else if (addr == `PEC_HOST_IF_CODE_HI)
         read_byte = reason_q[15:8];
   end
endfunction

// Read data holds until the next read strobe
always @(posedge clock)
begin
   if (rst)
   begin
      net_rdata_q <= `PEC_RDATA_RESET;
      host_rdata_q <= `PEC_RDATA_RESET;
   end
   else
   begin
      if (net_rd)
         net_rdata_q <= read_byte(net_addr);
      if (host_rd)
         host_rdata_q <= read_byte(host_addr);
   end
end

endmodule

// *** logic/pec_sat_cnt.v ***
`timescale 1ns/1ps

module pec_sat_cnt
(
   input wire clock,
   input wire rst,
   input wire clr,
   input wire inc,
   output reg [7:0] count_q
);

`include "pec_defs.vh"

// ----------------------------------------------------------------
// Saturating byte counter
// ----------------------------------------------------------------
// An event in the clearing cycle is kept: it counts as the first
always @(posedge clock)
begin
   if (rst)
      count_q <= `PEC_CNT_RESET;
   else if (inc)
   begin
      if (clr)
         count_q <= `PEC_CNT_ONE;
      else if (count_q != `PEC_CNT_MAX)
         count_q <= count_q + `PEC_CNT_ONE;
   end
   else if (clr)
      count_q <= `PEC_CNT_RESET;
end

endmodule

// *** test/pec_error_counters_chk.sv ***
`timescale 1ns/1ps

// ----
// Counter checks
// ----
module pec_error_counters_chk
#(
   parameter [2:0] HIF_VARIANT = 3'h0
)
(
   input wire clock,
   input wire rst,
   input wire [15:0] net_addr,
   input wire net_wr,
   input wire net_rd,
   input wire [7:0] net_rdata_q,
   input wire [15:0] host_addr,
   input wire host_rd,
   input wire [7:0] host_rdata_q,
   input wire [3:0] port_invalid_frame,
   input wire [3:0] port_rx_err,
   input wire [3:0] port_fwd_err,
   input wire frame_unit_err,
   input wire spi_err,
   input wire [2:0] spi_clk_cycles,
   input wire spi_busy_rd,
   input wire spi_no_term,
   input wire spi_after_term,
   input wire [2:0] spi_cmd,
   input wire spi_sel_mosi,
   input wire spi_sel_miso,
   input wire spi_ext_sel
);
   reg [7:0] code_q;
   reg [7:0] cnt_q;
   wire [1:0] top = spi_ext_sel ? {spi_sel_mosi, spi_sel_miso} : spi_cmd[2:1];
   wire hclr = net_wr && net_addr == 16'h030D;
   // Reference copy models the serial variant only
   wire quiet = HIF_VARIANT == 3'h0 && !spi_err && !net_wr;
   wire pev = |{port_invalid_frame, port_rx_err, port_fwd_err};
   wire pwr = net_wr && net_addr >= 16'h0300 && net_addr <= 16'h030B;
   wire prd = net_rd && net_addr >= 16'h0300 && net_addr <= 16'h030B;
   wire fwr = net_wr && net_addr == 16'h030C;
   wire hm = host_rd && !net_wr;
   // Reference copy; a new error wins over a clear
   always @(posedge clock)
   begin
      if (rst || (hclr && !spi_err))
      begin
         code_q <= 8'h00;
         cnt_q <= 8'h00;
      end
      else if (spi_err)
      begin
         code_q <= {top, spi_after_term, spi_no_term, spi_busy_rd,
            spi_clk_cycles};
         cnt_q <= (hclr ? 8'h00 : cnt_q) + {7'h00, hclr || cnt_q != 8'hFF};
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   port_clear_a:
      assert property (pwr && !pev ##1 prd |=> net_rdata_q == 8'h00)
      else $error("port counters not cleared");
   fu_clear_a:
      assert property (fwr && !frame_unit_err ##1 net_rd &&
         net_addr == 16'h030C |=> net_rdata_q == 8'h00)
      else $error("frame unit counter not cleared");
   host_cnt_a:
      assert property (net_rd && net_addr == 16'h030D && quiet
         |=> net_rdata_q == $past(cnt_q)) else $error("host count wrong");
   code_net_a:
      assert property (net_rd && net_addr == 16'h030E && quiet
         |=> net_rdata_q == $past(code_q)) else $error("reason code wrong");
   code_host_a:
      assert property (host_rd && host_addr == 16'h030E && quiet
         |=> host_rdata_q == $past(code_q)) else $error("host code wrong");
   code_high_a:
      assert property (host_rd && host_addr == 16'h030F
         |=> host_rdata_q == 8'h00) else $error("code high byte set");
   fu_sat_a:
      assert property ((hm && host_addr == 16'h030C) [*2]
         |=> host_rdata_q >= $past(host_rdata_q))
      else $error("frame unit count wrapped");
   inv_sat_a:
      assert property ((hm && host_addr == 16'h0302) [*2]
         |=> host_rdata_q >= $past(host_rdata_q))
      else $error("invalid frame count wrapped");
   cover property (spi_err);
   cover property (pwr);
   cover property (hm && host_rdata_q == 8'hFF);
endmodule

// *** test/pec_event_src.sv ***
`timescale 1ns/1ps

// ----
// Event source
// ----
module pec_event_src
(
   input wire clock,
   input wire start,
   input wire [13:0] sel,
   input wire [8:0] len,
   output reg [13:0] ev = 14'h0000,
   output wire busy
);
   reg [8:0] left_q = 9'h000;
   assign busy = left_q != 9'h000;
   // One pulse a cycle, so each one counts once
   always @(posedge clock)
   begin
      left_q <= start ? len : left_q - {8'h00, busy};
      ev <= busy ? sel : 14'h0000;
   end
endmodule

// *** test/test_pec_error_counters.sv ***
`timescale 1ns/1ps

// ----
// Register and event tests
// ----
module test_pec_error_counters;
   reg clock = 1'h0;
   reg rst = 1'h1;
   reg [15:0] net_addr = 16'h0000;
   reg [15:0] host_addr = 16'h0000;
   reg net_wr = 1'h0, net_rd = 1'h0, host_rd = 1'h0, start = 1'h0;
   wire [7:0] net_rdata_q, host_rdata_q;
   wire [7:0] m16_rdata, m8_rdata, mm_rdata, axi_rdata;
   reg [3:0] port_loop_open = 4'hF;
   wire [3:0] port_invalid_frame, port_rx_err, port_fwd_err;
   wire frame_unit_err, spi_err, busy;
   reg [2:0] spi_clk_cycles = 3'h5, spi_cmd = 3'h6;
   reg [2:0] axi_awsize = 3'h0, axi_arsize = 3'h0;
   reg spi_busy_rd = 1'h1, spi_no_term = 1'h0, spi_after_term = 1'h1;
   reg spi_sel_mosi = 1'h0, spi_sel_miso = 1'h0, spi_ext_sel = 1'h0;
   reg mcu_rd_end = 1'h0, mcu_wr_end = 1'h0, mcu_busy = 1'h0;
   reg mcu_addr0 = 1'h0, mcu_high_byte_enable_n = 1'h1;
   reg mm_read = 1'h0, mm_write = 1'h0, axi_awvalid = 1'h0;
   reg axi_awready = 1'h0, axi_wvalid = 1'h0, axi_wready = 1'h0;
   reg axi_arvalid = 1'h0, axi_arready = 1'h0;
   reg [13:0] sel = 14'h0000;
   reg [8:0] len = 9'h000;
   reg [7:0] e;
   wire [13:0] ev;
   integer fail_count = 0, n_checks = 0, cyc = 0, i, j;

   assign {spi_err, frame_unit_err, port_fwd_err, port_rx_err,
      port_invalid_frame} = ev;
   pec_error_counters dut (.*);
   pec_event_src src (.*);
   // One copy per other host variant; each reacts to its own pins only
   pec_error_counters #(.HIF_VARIANT(3'h2)) dut_mcu16
      (.*, .net_rdata_q(m16_rdata), .host_rdata_q());
   pec_error_counters #(.HIF_VARIANT(3'h1)) dut_mcu8
      (.*, .net_rdata_q(m8_rdata), .host_rdata_q());
   pec_error_counters #(.HIF_VARIANT(3'h3)) dut_mm
      (.*, .net_rdata_q(mm_rdata), .host_rdata_q());
   pec_error_counters #(.HIF_VARIANT(3'h4)) dut_axi
      (.*, .net_rdata_q(axi_rdata), .host_rdata_q());

   initial
      forever #12.5 clock = ~clock;

   task chk(input [7:0] got, input [7:0] exp);
   begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         fail_count = fail_count + 1;
         $display("[FAIL] %0t read %h expected %h", $time, got, exp);
      end
   end
   endtask

   // Both sides read the same byte; host side can only read
   task rd(input [15:0] a, input [7:0] exp);
   begin
      net_addr = a;
      host_addr = a;
      net_rd = 1'h1;
      host_rd = 1'h1;
      @(negedge clock);
      net_rd = 1'h0;
      host_rd = 1'h0;
      @(negedge clock);
      chk(net_rdata_q, exp);
      chk(host_rdata_q, exp);
   end
   endtask

   task wr(input [15:0] a);
   begin
      net_addr = a;
      net_wr = 1'h1;
      @(negedge clock);
      net_wr = 1'h0;
   end
   endtask

   // Host side keeps polling one byte while the events run
   task burst(input [13:0] s, input [8:0] n, input [15:0] a);
   begin
      sel = s;
      len = n;
      host_addr = a;
      host_rd = 1'h1;
      start = 1'h1;
      @(negedge clock);
      start = 1'h0;
      for (i = 0; i < 320 && busy; i = i + 1)
         @(negedge clock);
      host_rd = 1'h0;
      @(negedge clock);
   end
   endtask

   // One cycle of host pins: m = rd, wr, busy, addr0, enable_n;
   // x = awsize at 14:12, arsize at 10:8, handshakes at 5:0
   task pins(input [4:0] m, input [1:0] s, input [15:0] x);
   begin
      {mcu_rd_end, mcu_wr_end, mcu_busy, mcu_addr0,
         mcu_high_byte_enable_n} = m;
      {mm_read, mm_write} = s;
      {axi_awvalid, axi_awready, axi_wvalid, axi_wready, axi_arvalid,
         axi_arready} = x[5:0];
      axi_awsize = x[14:12];
      axi_arsize = x[10:8];
      @(negedge clock);
   end
   endtask

   task wrap_up;
   begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask

   always @(posedge clock)
   begin
      cyc = cyc + 1;
      if (cyc == 6000)
      begin
         fail_count = fail_count + 1;
         wrap_up;
      end
   end

   initial
   begin
      repeat (6) @(negedge clock);
      rst = 1'h0;
      for (j = 0; j < 17; j = j + 1)
         rd(16'h0300 + j[15:0], 8'h00);
      port_loop_open = 4'hE;
      burst(14'h0FFF, 9'h003, 16'h0301);
      for (j = 0; j < 4; j = j + 1)
      begin
         e = j ? 8'h03 : 8'h00;
         rd(16'h0300 + {j[14:0], 1'h0}, e);
         rd(16'h0301 + {j[14:0], 1'h0}, e);
         rd(16'h0308 + j[15:0], e);
      end
      port_loop_open = 4'hF;
      burst(14'h0002, 9'h104, 16'h0302);
      rd(16'h0302, 8'hFF);
      rd(16'h0303, 8'h03);
      burst(14'h0800, 9'h100, 16'h030B);
      rd(16'h030B, 8'hFF);
      burst(14'h1000, 9'h12C, 16'h030C);
      wr(16'h0305);
      for (j = 0; j < 12; j = j + 1)
         rd(16'h0300 + j[15:0], 8'h00);
      rd(16'h030C, 8'hFF);
      wr(16'h030C);
      rd(16'h030C, 8'h00);
      burst(14'h2000, 9'h001, 16'h030D);
      rd(16'h030E, 8'hED);
      {spi_ext_sel, spi_sel_miso, spi_no_term} = 3'h7;
      {spi_busy_rd, spi_after_term, spi_clk_cycles} = 5'h02;
      burst(14'h2000, 9'h001, 16'h030E);
      rd(16'h030D, 8'h02);
      wr(16'h030E);
      rd(16'h030E, 8'h52);
      rd(16'h030F, 8'h00);
      burst(14'h2000, 9'h12C, 16'h030D);
      rd(16'h030D, 8'hFF);
      wr(16'h030D);
      rd(16'h030D, 8'h00);
      rd(16'h030E, 8'h00);
      // Other variants: pins return to idle before each read
      pins(5'h15, 2'h0, 16'h0000);
      pins(5'h0F, 2'h0, 16'h0000);
      pins(5'h01, 2'h0, 16'h0000);
      rd(16'h030E, 8'h00);
      chk(m16_rdata, 8'h0A);
      chk(m8_rdata, 8'h02);
      pins(5'h13, 2'h0, 16'h0000);
      pins(5'h12, 2'h3, 16'h0000);
      pins(5'h01, 2'h3, 16'h0000);
      pins(5'h01, 2'h3, 16'h0000);
      pins(5'h01, 2'h0, 16'h0000);
      rd(16'h030D, 8'h00);
      chk(m16_rdata, 8'h03);
      chk(m8_rdata, 8'h02);
      chk(mm_rdata, 8'h01);
      rd(16'h030E, 8'h00);
      chk(m16_rdata, 8'h04);
      chk(m8_rdata, 8'h02);
      chk(mm_rdata, 8'h01);
      pins(5'h01, 2'h0, 16'h0028);
      pins(5'h01, 2'h0, 16'h0000);
      rd(16'h030E, 8'h00);
      chk(axi_rdata, 8'h03);
      pins(5'h01, 2'h0, 16'h2020);
      pins(5'h01, 2'h0, 16'h2030);
      pins(5'h01, 2'h0, 16'h3333);
      pins(5'h01, 2'h0, 16'h0000);
      rd(16'h030E, 8'h00);
      chk(axi_rdata, 8'h18);
      pins(5'h01, 2'h0, 16'h0002);
      pins(5'h01, 2'h0, 16'h0000);
      rd(16'h030E, 8'h00);
      chk(axi_rdata, 8'h04);
      rd(16'h030D, 8'h00);
      chk(axi_rdata, 8'h03);
      chk(m16_rdata, 8'h03);
      wrap_up;
   end
endmodule

bind pec_error_counters pec_error_counters_chk
   #(.HIF_VARIANT(HIF_VARIANT)) chk_i (.*);
